/* File: design/ccu_pkg.sv */
// Shared constants for the dual-array capture/compare unit.
// Assumes one 100 MHz system clock and plain configuration ports.
package ccu_pkg;

  // Structure
  localparam int NUM_ARR     = 2;
  localparam int CH_PER_ARR  = 16;
  localparam int NUM_CH      = 32;
  localparam int NUM_TMR     = 4;
  localparam int TMR_W       = 16;
  localparam int DBL_PAIRS   = 8;

  // Clock and staggered resolution
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAGGER_CYC   = 8;
  localparam logic [2:0] STAGGER_LAST = 3'(STAGGER_CYC - 1);

  // Timer clock sources
  localparam logic [1:0] SRC_PRESCALE = 2'h0;
  localparam logic [1:0] SRC_GP_OVF   = 2'h1;
  localparam logic [1:0] SRC_EXT      = 2'h2;

  // Channel modes: capture edges and compare modes 0 to 3
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_CAP_RISE = 3'h1;
  localparam logic [2:0] MODE_CAP_FALL = 3'h2;
  localparam logic [2:0] MODE_CAP_BOTH = 3'h3;
  localparam logic [2:0] MODE_CMP0     = 3'h4;
  localparam logic [2:0] MODE_CMP1     = 3'h5;
  localparam logic [2:0] MODE_CMP2     = 3'h6;
  localparam logic [2:0] MODE_CMP3     = 3'h7;

  // Reset values and timer maximum
  localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;
  localparam logic [TMR_W-1:0] CC_RESET  = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_MAX   = 16'hffff;
  localparam logic [7:0]       PRE_RESET = 8'h00;

endpackage

/* File: design/ccu_timebase.sv */
// One reloadable 16-bit time-base timer with prescaler and source select.
// Assumes base_tick, gp_ovf and ext_cnt_in are synchronous to ref_clk.
`timescale 1ns/10ps
module ccu_timebase
  import ccu_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               base_tick,
  input  wire logic               gp_ovf,
  input  wire logic               ext_cnt_in,
  input  wire logic               run,
  input  wire logic [1:0]         clk_src,
  input  wire logic [2:0]         prescale,
  input  wire logic [TMR_W-1:0]   reload_val,
  input  wire logic               load_now,
  output logic      [TMR_W-1:0]   count,
  output logic                    step,
  output logic                    ovf
);
  logic [7:0] pre_reg;
  logic [7:0] pre_mask;
  logic       ext_prev_reg;
  logic       adv;

  // Prescaler mask of 2^prescale ticks
  assign pre_mask = (8'h01 << prescale) - 8'h01;

  // Pick the advance event for the selected source
  always_comb
  begin
    unique case (clk_src)
      SRC_PRESCALE: adv = base_tick && ((pre_reg & pre_mask) == pre_mask);
      SRC_GP_OVF:   adv = gp_ovf;
      SRC_EXT:      adv = ext_cnt_in && !ext_prev_reg;
      default:      adv = 1'b0;
    endcase
  end

  // Prescaler runs on the base tick
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pre_reg <= PRE_RESET;
    else if (base_tick)
      pre_reg <= pre_reg + 8'h01;
  end

  // External count edge history
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ext_prev_reg <= 1'b0;
    else
      ext_prev_reg <= ext_cnt_in;
  end

  // Counter with reload on overflow
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= TMR_RESET;
      step  <= 1'b0;
      ovf   <= 1'b0;
    end
    else
    begin
      step <= run && adv && !load_now;
      ovf  <= run && adv && !load_now && (count == TMR_MAX);
      if (load_now)
        count <= reload_val;
      else if (run && adv)
      begin
        if (count == TMR_MAX)
          count <= reload_val;
        else
          count <= count + 16'h0001;
      end
    end
  end

endmodule

/* File: design/ccu_unit.sv */
// Dual-array capture/compare unit: four time bases, 32 channels, 32 pins.
// Assumes pins and count inputs are synchronous; config comes as plain ports.
//
// How it works
// - There are 32 channels, resolved every cycle; staggering slows only the prescaler base tick to once every 8 cycles.
// - Four 16-bit reloadable timers give each array two independent time bases.
// - Each timer counts a prescaled system clock or the general timer overflow.
// - The first timer of each array may count edges of an external input.
// - Each array has 16 registers, each set to either timer and capture or compare.
// - Compare mode 0 only raises requests unless it is a double register master, and may match several times a period.
// - Compare mode 1 toggles the pin on every match.
// - Compare mode 2 raises one request per timer period and drives the pin only as a double register master.
// - Compare mode 3 sets the pin on match and clears it on timer overflow, once a period.
// - Double register mode lets two registers toggle one shared pin on any match while the low register is in compare mode 0, 1 or 2.
// - A single-event option stops compare events after the first one.
// - Capture latches the allocated timer count on the selected pin event.
// - Each capture raises a request for that register.
// - The capture event is a rising, falling or either edge.
// - Compare registers are compared with their timer continuously and act on a match.
`timescale 1ns/10ps
module ccu_unit
  import ccu_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  input  wire logic                          staggered_en,
  input  wire logic                          gp_timer_ovf,
  input  wire logic [ccu_pkg::NUM_ARR-1:0]   ext_count_in,
  input  wire logic [ccu_pkg::NUM_TMR-1:0]   tmr_run,
  input  wire logic [ccu_pkg::NUM_TMR-1:0]   tmr_load,
  input  wire logic [2*ccu_pkg::NUM_TMR-1:0] tmr_clk_src,
  input  wire logic [3*ccu_pkg::NUM_TMR-1:0] tmr_prescale,
  input  wire logic [16*ccu_pkg::NUM_TMR-1:0] tmr_reload,
  output logic      [16*ccu_pkg::NUM_TMR-1:0] tmr_count,
  input  wire logic [3*ccu_pkg::NUM_CH-1:0]  cc_mode,
  input  wire logic [ccu_pkg::NUM_CH-1:0]    cc_tsel,
  input  wire logic [ccu_pkg::NUM_CH-1:0]    cc_single,
  input  wire logic [ccu_pkg::NUM_ARR-1:0]   dbl_reg_en,
  input  wire logic                          cc_wr_en,
  input  wire logic [4:0]                    cc_wr_idx,
  input  wire logic [ccu_pkg::TMR_W-1:0]     cc_wr_data,
  input  wire logic [4:0]                    cc_rd_idx,
  output logic      [ccu_pkg::TMR_W-1:0]     cc_rd_data,
  output logic      [ccu_pkg::NUM_CH-1:0]    cc_irq,
  output logic      [ccu_pkg::NUM_CH-1:0]    cc_done,
  input  wire logic [ccu_pkg::NUM_CH-1:0]    pin_in,
  output logic      [ccu_pkg::NUM_CH-1:0]    pin_out,
  output logic      [ccu_pkg::NUM_CH-1:0]    pin_oe
);
  import ccu_pkg::*;

  logic [2:0]       stag_reg;
  logic             hist_ok_reg;
  logic             base_tick;
  logic [TMR_W-1:0] tcnt  [NUM_TMR];
  logic [NUM_TMR-1:0] tstep;
  logic [NUM_TMR-1:0] tovf;
  logic [TMR_W-1:0] cc_val [NUM_CH];
  logic [NUM_CH-1:0] fire_w;

  // Staggered operation slows the base tick to one in eight
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      stag_reg <= 3'h0;
    else
      stag_reg <= stag_reg + 3'h1;
  end
  assign base_tick = !staggered_en || (stag_reg == STAGGER_LAST);

  // Pin history is trusted only one clock after reset, no false edge
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hist_ok_reg <= 1'b0;
    else
      hist_ok_reg <= 1'b1;
  end

  // Four time bases, external count on the first of each array
  genvar t;
  generate
    for (t = 0; t < NUM_TMR; t++)
    begin : g_tmr
      logic ext_w;
      if (t % 2 == 0)
      begin : g_ext
        assign ext_w = ext_count_in[t/2];
      end
      else
      begin : g_noext
        assign ext_w = 1'b0;
      end
      ccu_timebase u_tb (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .base_tick  (base_tick),
        .gp_ovf     (gp_timer_ovf),
        .ext_cnt_in (ext_w),
        .run        (tmr_run[t]),
        .clk_src    (tmr_clk_src[2*t +: 2]),
        .prescale   (tmr_prescale[3*t +: 3]),
        .reload_val (tmr_reload[16*t +: 16]),
        .load_now   (tmr_load[t]),
        .count      (tcnt[t]),
        .step       (tstep[t]),
        .ovf        (tovf[t])
      );
      assign tmr_count[16*t +: 16] = tcnt[t];
    end
  endgenerate

  // Register read port
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cc_rd_data <= CC_RESET;
    else
      cc_rd_data <= cc_val[cc_rd_idx];
  end

  // One capture/compare channel per pin
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++)
    begin : g_ch
      localparam int ARR = i / CH_PER_ARR;
      localparam int LOC = i % CH_PER_ARR;
      logic [2:0]       mode;
      logic [1:0]       tidx;
      logic [TMR_W-1:0] cnt;
      logic             stp;
      logic             tov;
      logic [TMR_W-1:0] val_reg;
      logic             armed_reg;
      logic             done_reg;
      logic             prev_reg;
      logic             pin_reg;
      logic             is_cmp;
      logic             match;
      logic             fire;
      logic             rise;
      logic             fall;
      logic             cap;
      logic             wr;
      logic             partner_fire;
      logic             is_slave;
      logic             own_drive;
      logic             dbl_master;
      logic             pin_set;
      logic             pin_clr;
      logic             pin_tgl;

      assign mode = cc_mode[3*i +: 3];
      assign tidx = {1'(ARR), cc_tsel[i]};
      assign cnt  = tcnt[tidx];
      assign stp  = tstep[tidx];
      assign tov  = tovf[tidx];
      assign wr   = cc_wr_en && (cc_wr_idx == 5'(i));

      // Continuous compare, acted on when the timer moves
      assign is_cmp = mode[2];
      assign match  = is_cmp && stp && (cnt == val_reg);

      // Mode 2 and 3 fire once per period; single event stops after one
      always_comb
      begin
        unique case (mode)
          MODE_CMP0, MODE_CMP1: fire = match && !done_reg;
          MODE_CMP2, MODE_CMP3: fire = match && armed_reg && !done_reg;
          default:              fire = 1'b0;
        endcase
      end
      assign fire_w[i] = fire;

      // Capture edge detection
      assign rise = hist_ok_reg && pin_in[i] && !prev_reg;
      assign fall = hist_ok_reg && !pin_in[i] && prev_reg;
      assign cap  = ((mode == MODE_CAP_RISE) && rise) ||
                    ((mode == MODE_CAP_FALL) && fall) ||
                    ((mode == MODE_CAP_BOTH) && (rise || fall));

      // Double register pairing: low eight drive, high eight feed them
      if (LOC < DBL_PAIRS)
      begin : g_master
        assign partner_fire = dbl_reg_en[ARR] && fire_w[i + DBL_PAIRS];
        assign is_slave     = 1'b0;
        assign dbl_master   = dbl_reg_en[ARR];
      end
      else
      begin : g_slave
        assign partner_fire = 1'b0;
        assign is_slave     = dbl_reg_en[ARR];
        assign dbl_master   = 1'b0;
      end

      // Pin history for edge detection
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          prev_reg <= 1'b0;
        else
          prev_reg <= pin_in[i];
      end

      // Register value: capture beats a software write
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          val_reg <= CC_RESET;
        else if (cap)
          val_reg <= cnt;
        else if (wr)
          val_reg <= cc_wr_data;
      end
      assign cc_val[i] = val_reg;

      // Once-per-period arm, overflow re-arms
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          armed_reg <= 1'b1;
        else if (tov)
          armed_reg <= 1'b1;
        else if (fire)
          armed_reg <= 1'b0;
      end

      // Single-event lock, a fresh write releases it
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          done_reg <= 1'b0;
        else if (fire && cc_single[i])
          done_reg <= 1'b1;
        else if (wr || !is_cmp)
          done_reg <= 1'b0;
      end
      assign cc_done[i] = done_reg;

      // Interrupt request pulse per capture or compare event
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          cc_irq[i] <= 1'b0;
        else
          cc_irq[i] <= cap || fire;
      end

      // Pin action per mode; a double-mode master outside mode 3 inverts on either match
      always_comb
      begin
        pin_set = 1'b0;
        pin_clr = 1'b0;
        pin_tgl = partner_fire;
        unique case (mode)
          MODE_CMP1:
          begin
            pin_tgl = fire ^ partner_fire;
          end
          MODE_CMP3:
          begin
            pin_set = fire;
            pin_clr = tov;
            pin_tgl = 1'b0;
          end
          MODE_CMP0, MODE_CMP2:
          begin
            pin_tgl = (dbl_master && fire) ^ partner_fire;
          end
          MODE_OFF, MODE_CAP_RISE, MODE_CAP_FALL, MODE_CAP_BOTH:
          begin
            pin_tgl = partner_fire;
          end
        endcase
      end

      // Compare output latch, a match beats the overflow clear
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          pin_reg <= 1'b0;
        else if (pin_set)
          pin_reg <= 1'b1;
        else if (pin_clr)
          pin_reg <= 1'b0;
        else if (pin_tgl)
          pin_reg <= !pin_reg;
      end

      // Pin drive only in output-producing compare modes
      always_comb
      begin
        unique case (mode)
          MODE_CMP1, MODE_CMP3: own_drive = 1'b1;
          MODE_CMP0, MODE_CMP2: own_drive = dbl_master;
          MODE_OFF, MODE_CAP_RISE, MODE_CAP_FALL, MODE_CAP_BOTH: own_drive = 1'b0;
        endcase
      end
      assign pin_out[i] = pin_reg;
      assign pin_oe[i]  = own_drive && !is_slave;
    end
  endgenerate

endmodule

/* File: test/ccu_pin_model.sv */
// Far-side model of the unit's port pins.
// Assumes the bench sets each pin's free level.
`timescale 1ns/10ps
module ccu_pin_model
  import ccu_pkg::*;
(
  input  wire logic [NUM_CH-1:0] pin_out,
  input  wire logic [NUM_CH-1:0] pin_oe,
  input  wire logic [NUM_CH-1:0] lvl,
  output logic      [NUM_CH-1:0] pin_in
);
  // Driven pins read back the device level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
endmodule

/* File: test/ccu_unit_sva.sv */
// Checker for the unit, watching channel 0 and timer 0.
// Assumes channel 0 stays allocated to timer 0.
`timescale 1ns/10ps
module ccu_unit_sva
  import ccu_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  reset_n,
  input wire logic [16*NUM_TMR-1:0] tmr_count,
  input wire logic [16*NUM_TMR-1:0] tmr_reload,
  input wire logic [3*NUM_CH-1:0]   cc_mode,
  input wire logic [NUM_CH-1:0]     cc_single,
  input wire logic [NUM_ARR-1:0]    dbl_reg_en,
  input wire logic [NUM_CH-1:0]     cc_irq,
  input wire logic [NUM_CH-1:0]     cc_done,
  input wire logic [NUM_CH-1:0]     pin_in,
  input wire logic [NUM_CH-1:0]     pin_out,
  input wire logic [NUM_CH-1:0]     pin_oe
);
  logic [15:0] cnt;
  logic [2:0]  md;
  // Channel 0 and timer 0 views
  assign cnt = tmr_count[15:0];
  assign md = cc_mode[2:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  tmr_step_a: assert property ($changed(cnt) |-> cnt == $past(cnt) + 16'h1
    || cnt == $past(tmr_reload[15:0])) else $error("timer 0 jumped");
  tmr_reload_a: assert property ($past(cnt) == TMR_MAX && $changed(cnt)
    |-> cnt == $past(tmr_reload[15:0])) else $error("no reload on overflow");
  cmp_toggle_a: assert property (cc_irq[0] && $past(md) == MODE_CMP1 && !dbl_reg_en[0]
    |-> pin_out[0] != $past(pin_out[0])) else $error("pin did not toggle");
  cmp_set_a: assert property (cc_irq[0] && $past(md) == MODE_CMP3
    && !dbl_reg_en[0] |-> pin_out[0]) else $error("pin not set");
  cmp_clear_a: assert property (md == MODE_CMP3 && $past(md) == MODE_CMP3
    && $past(cnt) == TMR_MAX && $changed(cnt) && !dbl_reg_en[0]
    |=> !pin_out[0] || cc_irq[0]) else $error("pin not cleared");
  quiet_pin_a: assert property ((md == MODE_CMP0 || md == MODE_CMP2) && !dbl_reg_en[0]
    |-> !pin_oe[0]) else $error("pin driven");
  drive_pin_a: assert property (md == MODE_CMP1 || md == MODE_CMP3
    |-> pin_oe[0]) else $error("pin not driven");
  cap_rise_a: assert property (md == MODE_CAP_RISE && $rose(pin_in[0])
    |=> cc_irq[0]) else $error("capture request missing");
  cap_quiet_a: assert property (md == MODE_CAP_FALL && $past(md) == MODE_CAP_FALL
    && !$fell(pin_in[0]) |=> !cc_irq[0]) else $error("capture on wrong edge");
  single_lock_a: assert property (cc_single[0] && cc_done[0] && $past(cc_done[0])
    |-> !cc_irq[0]) else $error("event after lock");
  // Main scenarios
  cover property (cc_irq[0] && md == MODE_CMP3);
  cover property (md == MODE_CAP_RISE && $rose(pin_in[0]));
  cover property (cc_done[0]);
endmodule
bind ccu_unit ccu_unit_sva u_ccu_unit_sva (.ref_clk, .reset_n, .tmr_count, .tmr_reload,
  .cc_mode, .cc_single, .dbl_reg_en, .cc_irq, .cc_done, .pin_in, .pin_out, .pin_oe);

/* File: test/testbench.sv */
// Self-checking bench for the capture/compare unit.
// Assumes the pin model and the bound checker.
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) \
    begin \
      mismatches++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module testbench;
  import ccu_pkg::*;
  logic        ref_clk, reset_n, staggered_en, gp_timer_ovf, cc_wr_en;
  logic [1:0]  ext_count_in, dbl_reg_en;
  logic [3:0]  tmr_run, tmr_load;
  logic [7:0]  tmr_clk_src;
  logic [11:0] tmr_prescale;
  logic [63:0] tmr_reload, tmr_count;
  logic [95:0] cc_mode;
  logic [31:0] cc_tsel, cc_single, cc_irq, cc_done, pin_in, pin_out, pin_oe, lvl;
  logic [4:0]  cc_wr_idx, cc_rd_idx;
  logic [15:0] cc_wr_data, cc_rd_data, v, r, cap;
  int          mismatches, num_checks, n, acc;
  ccu_unit u_ccu_unit (.*);
  ccu_pin_model u_ccu_pin_model (.pin_out, .pin_oe, .lvl, .pin_in);
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic wr(input int ch, input logic [15:0] d);
    cc_wr_idx = 5'(ch);
    cc_wr_data = d;
    cc_wr_en = 1'b1;
    cyc(1);
    cc_wr_en = 1'b0;
  endtask
  task automatic rd(input int ch, input logic [15:0] e);
    cc_rd_idx = 5'(ch);
    cyc(1);
    `CHK(cc_rd_data, e)
  endtask
  task automatic ld(input int t, input logic [15:0] d);
    tmr_reload[16*t+:16] = d;
    tmr_load[t] = 1'b1;
    cyc(1);
    tmr_load[t] = 1'b0;
  endtask
  // Timer value k steps after a load of rl
  function automatic logic [15:0] adv(input logic [15:0] rl, input int k);
    logic [15:0] c;
    c = rl;
    repeat (k) c = (c == TMR_MAX) ? rl : c + 16'h1;
    return c;
  endfunction
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    {staggered_en, gp_timer_ovf, cc_wr_en, ext_count_in, dbl_reg_en} = '0;
    {tmr_run, tmr_load, tmr_clk_src, tmr_prescale, tmr_reload} = '0;
    {cc_mode, cc_tsel, cc_single, lvl, cc_wr_idx, cc_wr_data, cc_rd_idx} = '0;
    mismatches = 0;
    num_checks = 0;
    cap = CC_RESET;
    reset_n = 1'b0;
    void'($urandom(44140));
    cyc(2);
    reset_n = 1'b1;
    `CHK(tmr_count, 64'h0)
    rd(5, CC_RESET);
    // Run and reload of timer 0
    r = 16'hfff0 - 16'($urandom_range(15));
    tmr_run[0] = 1'b1;
    ld(0, r);
    acc = 0;
    repeat (3)
    begin
      n = $urandom_range(40, 1);
      acc += n;
      cyc(n);
      `CHK(tmr_count[15:0], adv(r, acc))
    end
    // Overflow pulses and external count inputs
    tmr_clk_src = 8'h24;
    tmr_run = 4'h6;
    ld(1, 16'h0);
    ld(2, 16'h0);
    n = $urandom_range(9, 1);
    repeat (n)
    begin
      {gp_timer_ovf, ext_count_in[1]} = 2'h3;
      cyc(1);
      {gp_timer_ovf, ext_count_in[1]} = 2'h0;
      cyc(1);
    end
    cyc(2);
    `CHK(tmr_count[31:16], 16'(n))
    `CHK(tmr_count[47:32], 16'(n))
    // Capture on each edge choice, timer held
    tmr_run = 4'h0;
    for (int m = 1; m < 4; m++)
    begin
      cc_mode[2:0] = 3'(m);
      for (int e = 0; e < 2; e++)
      begin
        v = 16'($urandom);
        ld(0, v);
        lvl[0] = ~lvl[0];
        cyc(1);
        `CHK(cc_irq[0], 1'(m == 3 || m == e + 1))
        if (m == 3 || m == e + 1)
          cap = v;
        rd(0, cap);
      end
    end
    // Compare modes 0 to 3, then mode 1 single
    for (int k = 0; k < 5; k++)
    begin
      tmr_run[0] = 1'b0;
      cc_mode[2:0] = (k == 4) ? MODE_CMP1 : 3'(4 + k);
      cc_single[0] = (k == 4);
      wr(0, 16'hffe8);
      ld(0, 16'hffe0);
      tmr_run[0] = 1'b1;
      n = 0;
      for (int i = 0; i < 46; i++)
      begin
        if (i == 12 && k < 4)
          wr(0, 16'hfff4);
        else
          cyc(1);
        n += (cc_irq[0] === 1'b1);
      end
      `CHK(n, (k < 2) ? 2 : 1)
      `CHK(pin_out[0], 1'(k == 4))
      `CHK(pin_oe[0], 1'(k == 1 || k >= 3))
      `CHK(cc_done[0], 1'(k == 4))
    end
    // Double register mode after a second reset
    reset_n = 1'b0;
    dbl_reg_en[0] = 1'b1;
    cc_single[0] = 1'b0;
    tmr_run[0] = 1'b0;
    cc_mode[26:24] = MODE_CMP0;
    cc_mode[2:0] = MODE_CMP0;
    cyc(1);
    reset_n = 1'b1;
    wr(0, 16'hffe8);
    cyc(1);
    wr(8, 16'hfff4);
    ld(0, 16'hffe0);
    tmr_run[0] = 1'b1;
    cyc(14);
    `CHK(pin_out[0], 1'b1)
    cyc(12);
    `CHK(pin_out[0], 1'b0)
    `CHK({pin_oe[8], pin_oe[0]}, 2'b01)
    // Staggered resolution on timer 3
    staggered_en = 1'b1;
    tmr_prescale[11:9] = 3'h1;
    tmr_run[3] = 1'b1;
    ld(3, 16'h0);
    cyc(160);
    `CHK(tmr_count[63:48], 16'h000a)
    complete_run();
  end
endmodule
